//--- hdl/driver_diag_protection_monitor.sv
// diagnostic and protection monitor for a two-phase stepper driver
`timescale 1ns/1ps
// Function
// R01: open-load flag when no chop per polarity
// R02: hold flag when current below one sixteenth
// R03: open-load flags never affect driving
// R04: host reads open-load during microstepping only
// R05: evaluate prewarn, release and two shutdown levels
// R06: warning bit follows prewarning threshold
// R07: shutdown level disables driver, sets flag
// R08: stay off until below release level
// R09: select bit picks high or reduced shutdown
// R10: compensated slope steps gate current when warm
// R11: undervoltage resets logic, disables all transistors
// R12: undervoltage clears every register to zero
// R13: cleared current scale reports zero current
// R14: host checks zero current for undervoltage
// R15: low-supply bit picks threshold and damping
// R16: undervoltage detector is power-up reset
// R17: serial unit held in reset during start-up
// R18: i/o supply included in undervoltage reset
// R19: comparators synchronised before use
module driver_diag_protection_monitor
  import diag_pkg::*;
#(
  parameter int STARTUP_CYCLES = STARTUP_CYC
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire analog_in_t analogIn,
  input wire coil_obs_t coilA,
  input wire coil_obs_t coilB,
  input wire logic cfgWrite,
  input wire logic [CUR_W-1:0] cfgCurrentScale,
  input wire logic cfgLowShutdownThresholdSel,
  input wire logic cfgLowSupplyAndDampingEnable,
  input wire logic [1:0] cfgHighSideSlopeSetting,
  input wire logic driverRequest,
  output status_t status,
  output logic [CUR_W-1:0] actualCurrentValue,
  output logic driverEnable,
  output logic powerStageOff,
  output logic [1:0] highSideGateCurrent,
  output logic dampingEnable,
  output logic serialResetN,
  output logic linkClkRise,
  output logic logicResetN
);

  // ************************************************************
  // input synchronisation
  // ************************************************************
  analog_in_t syncIn;

  // every comparator and the link clock pass two flops
  sync_bank #(
    .W(SYNC_W)
  ) u_sync (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .din(analogIn),
    .dout(syncIn)
  ); // R19

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [CUR_W-1:0] currentScale;            // stored current scale
    logic lowShutdownThresholdSel;             // reduced shutdown select
    logic lowSupplyAndDampingEnable;           // low supply and damping
    logic [1:0] highSideSlopeSetting;          // stored slope setting
    logic [NUM_COILS-1:0] olFlag;              // open-load flags
    logic [NUM_COILS-1:0] chopSeen;            // chop seen in present polarity
    logic [NUM_COILS-1:0] lastPol;             // polarity last cycle
    logic [NUM_COILS-1:0] polValid;            // a polarity period has started
    logic prewarn;                             // warning flag
    logic shutdown;                            // shutdown latch
    logic uvReset;                             // undervoltage active
    logic [15:0] startCnt;                     // start-up counter
    logic started;                             // start-up complete
    logic drvEn;                               // driver enable out
    logic [1:0] gateCur;                       // high-side gate current out
    logic [CUR_W-1:0] curOut;                  // reported current
    logic linkPrev;                            // link clock last sample
    logic linkRise;                            // link clock edge pulse
    logic stageOff; // power stage off out, registered
    logic logicRstN; // logic reset out, low in undervoltage
  } mon_state_t;

  mon_state_t s_q;
  mon_state_t s_d;

  coil_obs_t coils [NUM_COILS];
  logic [NUM_COILS-1:0] currentOk;
  logic uvNow;
  logic shutLevel;

  assign coils[0] = coilA;
  assign coils[1] = coilB;

  // ************************************************************
  // current gate for open-load evaluation
  // ************************************************************
  // a coil at very low current cannot show chopping, so the flag holds
  genvar gi;
  generate
    for (gi = 0; gi < NUM_COILS; gi++) begin : g_curok
      assign currentOk[gi] =
        coils[gi].actualCurrent >= (CUR_MAX >> CUR_SIXTEENTH_SHIFT); // R02
    end
  endgenerate

  // undervoltage: threshold picked by the low supply bit, i/o included
  assign uvNow = (s_q.lowSupplyAndDampingEnable ? syncIn.coreUnderLow
                                               : syncIn.coreUnderHigh) // R15
                 | syncIn.ioUnder; // R18

  // shutdown comparator picked by the threshold select
  assign shutLevel = s_q.lowShutdownThresholdSel ? syncIn.tempShutLow
                                                 : syncIn.tempShutHigh; // R09

  // ************************************************************
  // next-state logic
  // ************************************************************
  always_comb begin
    s_d = s_q;
    s_d.linkPrev = syncIn.linkClk;
    s_d.linkRise = syncIn.linkClk & ~s_q.linkPrev;
    s_d.uvReset = uvNow;
    if (uvNow) begin
      // undervoltage acts as a full reset of the logic
      s_d = '0; // R11 R12 R16
      s_d.uvReset = 1'b1;
    end else if (!s_q.started) begin
      // start-up: serial unit held, configuration writes ignored
      // track polarity here so the cleared copy cannot fake a change later
      for (int i = 0; i < NUM_COILS; i++) begin
        s_d.lastPol[i] = coils[i].polarity;
      end
      if (s_q.startCnt >= 16'(STARTUP_CYCLES - 1)) begin
        s_d.started = 1'b1; // R17
      end else begin
        s_d.startCnt = s_q.startCnt + 16'h0001;
      end
    end else begin
      // configuration capture from the serial unit
      if (cfgWrite) begin
        s_d.currentScale = cfgCurrentScale;
        s_d.lowShutdownThresholdSel = cfgLowShutdownThresholdSel;
        s_d.lowSupplyAndDampingEnable = cfgLowSupplyAndDampingEnable;
        s_d.highSideSlopeSetting = cfgHighSideSlopeSetting;
      end
      // open-load per coil: judged at each polarity change
      for (int i = 0; i < NUM_COILS; i++) begin
        s_d.lastPol[i] = coils[i].polarity;
        if (coils[i].polarity != s_q.lastPol[i]) begin
          if (s_q.polValid[i] && currentOk[i]) begin
            s_d.olFlag[i] = ~s_q.chopSeen[i]; // R01
          end
          s_d.polValid[i] = 1'b1;
          s_d.chopSeen[i] = coils[i].chopEvent;
        end else if (coils[i].chopEvent) begin
          s_d.chopSeen[i] = 1'b1;
        end
      end
      // temperature
      s_d.prewarn = syncIn.tempPrewarn; // R05 R06
      if (shutLevel) begin
        s_d.shutdown = 1'b1; // R07
      end else if (!syncIn.tempRelease) begin
        s_d.shutdown = 1'b0; // R08
      end
    end
    // outputs; open-load flags deliberately not in this term
    s_d.drvEn = !uvNow && s_d.started && !s_d.shutdown && driverRequest; // R03 R07
    // both views are registered so no output passes through a gate
    s_d.stageOff = ~s_d.drvEn; // R11
    s_d.logicRstN = ~s_d.uvReset; // R16
    // compensated modes gain one step once warm
    if (s_d.prewarn && (s_d.highSideSlopeSetting == SLOPE_MIN_TC ||
                        s_d.highSideSlopeSetting == SLOPE_MED_TC)) begin
      s_d.gateCur = s_d.highSideSlopeSetting + 2'h1; // R10
    end else begin
      s_d.gateCur = s_d.highSideSlopeSetting;
    end
    // reported current is zero while the scale is cleared
    s_d.curOut = (s_d.currentScale == '0) ? '0 : coilA.actualCurrent; // R13
  end

  // registers: constant reset only; the stage stays off and the logic
  // reset output stays high while the pin reset is held
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
      s_q.stageOff <= 1'b1;
      s_q.logicRstN <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign status.openLoad = s_q.olFlag;
  assign status.tempPrewarningFlag = s_q.prewarn;
  assign status.tempShutdownFlag = s_q.shutdown;
  assign actualCurrentValue = s_q.curOut;
  assign driverEnable = s_q.drvEn;
  assign powerStageOff = s_q.stageOff; // R11
  assign highSideGateCurrent = s_q.gateCur;
  assign dampingEnable = s_q.lowSupplyAndDampingEnable; // R15
  assign serialResetN = s_q.started; // R17
  assign linkClkRise = s_q.linkRise;
  assign logicResetN = s_q.logicRstN; // R16

  // ************************************************************
  // assertions
  // ************************************************************
  // a shut-down stage never drives
  a_shut_disables: assert property (@(posedge sys_clk) disable iff (!nrst) // R07
    s_q.shutdown |-> !driverEnable)
    else $error("driver on while shut down");

  // the latch holds while still above the release level
  a_shut_release: assert property (@(posedge sys_clk) disable iff (!nrst) // R08
    (s_q.started && !uvNow && syncIn.tempRelease && !shutLevel && s_q.shutdown)
    |=> s_q.shutdown)
    else $error("shutdown left above release");

  // reaching the chosen shutdown level sets the flag next cycle
  a_shut_set: assert property (@(posedge sys_clk) disable iff (!nrst) // R07
    (s_q.started && !uvNow && shutLevel) |=> status.tempShutdownFlag)
    else $error("shutdown flag not set");

  // the reduced level trips when it is selected
  a_shut_low_sel: assert property (@(posedge sys_clk) disable iff (!nrst) // R09
    (s_q.started && !uvNow && s_q.lowShutdownThresholdSel && syncIn.tempShutLow)
    |=> status.tempShutdownFlag)
    else $error("reduced shutdown level ignored");

  // with the higher level selected the reduced comparator is harmless
  a_shut_high_sel: assert property (@(posedge sys_clk) disable iff (!nrst) // R09
    (s_q.started && !uvNow && !s_q.lowShutdownThresholdSel && !syncIn.tempShutHigh
     && !s_q.shutdown) |=> !status.tempShutdownFlag)
    else $error("shutdown without higher level");

  // below release with no shutdown level, a requested driver comes back
  a_shut_reenable: assert property (@(posedge sys_clk) disable iff (!nrst) // R08
    (s_q.started && !uvNow && !shutLevel && !syncIn.tempRelease && driverRequest)
    |=> driverEnable)
    else $error("driver not re-enabled below release");

  // the warning flag follows the synchronised comparator
  a_warn_follow: assert property (@(posedge sys_clk) disable iff (!nrst) // R06
    (s_q.started && !uvNow) |=> status.tempPrewarningFlag == $past(syncIn.tempPrewarn))
    else $error("warning flag wrong");

  // undervoltage wipes flags and scale and stops the stage
  a_uv_clear: assert property (@(posedge sys_clk) disable iff (!nrst) // R12
    uvNow |=> (s_q.olFlag == '0 && s_q.currentScale == '0 && !driverEnable))
    else $error("undervoltage did not clear");

  // undervoltage holds the logic and the serial unit in reset
  a_uv_reset_out: assert property (@(posedge sys_clk) disable iff (!nrst) // R11
    uvNow |=> (!logicResetN && powerStageOff && !serialResetN))
    else $error("undervoltage outputs wrong");

  // the i/o supply alone is enough to reset
  a_uv_io: assert property (@(posedge sys_clk) disable iff (!nrst) // R18
    syncIn.ioUnder |=> !logicResetN)
    else $error("i/o undervoltage missed");

  // with the low-supply bit cleared the higher threshold resets
  a_uv_high_thr: assert property (@(posedge sys_clk) disable iff (!nrst) // R15
    (!s_q.lowSupplyAndDampingEnable && syncIn.coreUnderHigh) |=> !logicResetN)
    else $error("higher supply threshold missed");

  // the stage-off output is always the inverse of the enable
  a_stage_inverse: assert property (@(posedge sys_clk) disable iff (!nrst) // R11
    powerStageOff == !driverEnable)
    else $error("stage off and enable disagree");

  // a cleared scale reports zero current
  a_zero_current: assert property (@(posedge sys_clk) disable iff (!nrst) // R13
    (s_q.currentScale == '0) |-> ##1 (actualCurrentValue == '0 || $past(cfgWrite)))
    else $error("nonzero current with cleared scale");

  // a set scale reports the coil A current of the cycle before
  a_cur_report: assert property (@(posedge sys_clk) disable iff (!nrst) // R13
    (s_q.currentScale != '0) |-> actualCurrentValue == $past(coilA.actualCurrent))
    else $error("reported current wrong");

  // start-up holds the serial unit and the stage
  a_startup_hold: assert property (@(posedge sys_clk) disable iff (!nrst) // R17
    !s_q.started |-> (!serialResetN && !driverEnable))
    else $error("serial unit out of reset early");

  // configuration is ignored until start-up ends
  a_startup_cfg: assert property (@(posedge sys_clk) disable iff (!nrst) // R17
    !s_q.started |=> $stable(s_q.currentScale))
    else $error("write taken during start-up");

  // a configuration write in service reaches the damping output
  a_damp_write: assert property (@(posedge sys_clk) disable iff (!nrst) // R15
    (s_q.started && !uvNow && cfgWrite)
    |=> dampingEnable == $past(cfgLowSupplyAndDampingEnable))
    else $error("damping bit not taken");

  // compensated minimum steps to medium when warm
  a_gate_step: assert property (@(posedge sys_clk) disable iff (!nrst) // R10
    (s_q.prewarn && s_q.highSideSlopeSetting == SLOPE_MIN_TC)
    |-> highSideGateCurrent == SLOPE_MED_TC)
    else $error("gate current not stepped");

  // compensated medium steps to maximum when warm
  a_gate_step_med: assert property (@(posedge sys_clk) disable iff (!nrst) // R10
    (s_q.prewarn && s_q.highSideSlopeSetting == SLOPE_MED_TC)
    |-> highSideGateCurrent == SLOPE_MAX)
    else $error("medium gate current not stepped");

  // below the warning level the setting passes unchanged
  a_gate_plain: assert property (@(posedge sys_clk) disable iff (!nrst) // R10
    !s_q.prewarn |-> highSideGateCurrent == s_q.highSideSlopeSetting)
    else $error("gate current stepped while cool");

  // open-load is judged at a polarity change from the period's chop record
  a_ol_judge: assert property (@(posedge sys_clk) disable iff (!nrst) // R01
    (s_q.started && !uvNow && coils[0].polarity != s_q.lastPol[0] && s_q.polValid[0]
     && currentOk[0]) |=> status.openLoad[0] == !$past(s_q.chopSeen[0]))
    else $error("open-load judged wrong");

  // low current leaves the flag alone
  a_ol_hold_low: assert property (@(posedge sys_clk) disable iff (!nrst) // R02
    (!currentOk[0] && !uvNow) |=> $stable(s_q.olFlag[0]))
    else $error("open-load changed at low current");

  // a set open-load flag never stops a requested driver
  a_ol_no_stop: assert property (@(posedge sys_clk) disable iff (!nrst) // R03
    (s_q.started && !uvNow && !shutLevel && !s_q.shutdown && driverRequest
     && status.openLoad != '0) |=> driverEnable)
    else $error("open-load stopped the driver");

  // a synchronised rising link clock gives one pulse
  a_link_rise: assert property (@(posedge sys_clk) disable iff (!nrst) // R19
    (syncIn.linkClk && !s_q.linkPrev && !uvNow) |=> linkClkRise)
    else $error("link clock edge missed");

endmodule

//--- hdl/diag_pkg.sv
// shared types and constants for the driver diagnostic and protection monitor
package diag_pkg;

  // ************************************************************
  // widths and encodings
  // ************************************************************
  localparam int CUR_W = 5;                    // current scale width
  localparam logic [4:0] CUR_MAX = 5'h1F;      // maximum current setting
  localparam int CUR_SIXTEENTH_SHIFT = 4;      // one sixteenth of max
  localparam logic [1:0] SLOPE_MIN = 2'h0;     // minimum gate current
  localparam logic [1:0] SLOPE_MIN_TC = 2'h1;  // minimum, compensated
  localparam logic [1:0] SLOPE_MED_TC = 2'h2;  // medium, compensated
  localparam logic [1:0] SLOPE_MAX = 2'h3;     // maximum gate current
  localparam int NUM_COILS = 2;                // coil A and coil B
  localparam int SYNC_W = 8;                   // analog inputs synchronised

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_HZ = 25000000;            // system clock rate
  localparam int STARTUP_NS = 1000;            // least hold of start-up reset
  localparam int STARTUP_CYC = (STARTUP_NS * (CLK_HZ / 1000000) + 999) / 1000;

  // per-coil chopper observation from the driver core
  typedef struct packed {
    logic polarity;                            // present coil current sign
    logic chopEvent;                           // one-cycle chopper event
    logic [CUR_W-1:0] actualCurrent;           // present coil current magnitude
  } coil_obs_t;

  // raw comparator levels from the analog monitors
  typedef struct packed {
    logic tempPrewarn;                         // above the pre-warning level
    logic tempRelease;                         // above the release level
    logic tempShutHigh;                        // above the higher shutdown level
    logic tempShutLow;                         // above the reduced shutdown level
    logic coreUnderHigh;                       // core supply below higher threshold
    logic coreUnderLow;                        // core supply below lower threshold
    logic ioUnder;                             // i/o supply below threshold
    logic linkClk;                             // serial link clock pin
  } analog_in_t;

  // status flags handed to the serial status path
  typedef struct packed {
    logic [NUM_COILS-1:0] openLoad;            // per-coil open-load flags
    logic tempPrewarningFlag;                  // pre-warning reached
    logic tempShutdownFlag;                    // driver shut down for heat
  } status_t;

endpackage

//--- hdl/sync_bank.sv
// two-stage synchroniser bank for asynchronous level inputs
`timescale 1ns/1ps
module sync_bank #(
  parameter int W = 8
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [W-1:0] meta;                        // first stage, read only by second
    logic [W-1:0] stable;                      // second stage
  } sync_state_t;

  sync_state_t s_q;
  sync_state_t s_d;

  // next-state: shift one stage per edge
  always_comb begin
    s_d = s_q;
    s_d.meta = din;
    s_d.stable = s_q.meta;
  end

  // registers: constant reset value only
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign dout = s_q.stable;

endmodule

//--- testbench/host_model.sv
// host side model: makes link clock frames once the serial unit is out of reset
`timescale 1ns/1ps
module host_model (
  input wire logic serialResetN,
  input wire logic frameGo,
  output logic linkClk
);
  // ************************************************************
  // frame maker
  // ************************************************************
  // the clock stands low between frames, 320 ns period inside one
  initial begin
    linkClk = 1'b0;
    forever begin
      @(posedge frameGo);
      // no access is tried while the serial unit is held in reset
      if (serialResetN === 1'b1) begin
        #7;
        repeat (8) begin
          linkClk = 1'b1;
          #160;
          linkClk = 1'b0;
          #160;
        end
      end
    end
  end
endmodule

//--- testbench/driver_diag_protection_monitor_test.sv
// self-checking bench for the diagnostic and protection monitor
`timescale 1ns/1ps
module driver_diag_protection_monitor_test;
  import diag_pkg::*;
  // ************************************************************
  // stimulus and observed signals
  // ************************************************************
  logic sys_clk = 0, nrst = 0, cfgWrite = 0, lowSel = 0, lowSup = 0;
  logic driverRequest = 0, frameGo = 0, hostClk;
  logic [CUR_W-1:0] cfgScale = 0, acv;
  logic [1:0] cfgSlope = 0, gate;
  analog_in_t ain = '0, anIn;
  coil_obs_t cA = '0, cB = '0;
  status_t status;
  logic drvEn, pso, dmp, srn, lcr, lrn;
  int n_errors = 0, checked = 0, rises = 0, seed = 32'h6538, s, rc;
  int olPrev[2] = '{0, 0}; // model: a polarity change already seen
  int olExp[2] = '{0, 0}; // model: expected open-load flags
  always #20 sys_clk = ~sys_clk;
  // link clock pin comes from the host model, the rest from the bench
  always_comb begin
    anIn = ain;
    anIn.linkClk = hostClk;
  end
  always @(posedge sys_clk) if (lcr === 1'b1) rises <= rises + 1;
  driver_diag_protection_monitor #(.STARTUP_CYCLES(2)) driver_diag_protection_monitor_i (
    .sys_clk(sys_clk), .nrst(nrst), .analogIn(anIn), .coilA(cA), .coilB(cB),
    .cfgWrite(cfgWrite), .cfgCurrentScale(cfgScale), .cfgLowShutdownThresholdSel(lowSel),
    .cfgLowSupplyAndDampingEnable(lowSup), .cfgHighSideSlopeSetting(cfgSlope),
    .driverRequest(driverRequest), .status(status), .actualCurrentValue(acv),
    .driverEnable(drvEn), .powerStageOff(pso), .highSideGateCurrent(gate),
    .dampingEnable(dmp), .serialResetN(srn), .linkClkRise(lcr), .logicResetN(lrn));
  host_model host_model_i (.serialResetN(srn), .frameGo(frameGo), .linkClk(hostClk));
  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  // bench inputs change one ns after the rising edge, the host link clock eight ns after
  task automatic cyc(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic cfg(logic [4:0] sc, logic sel, logic sup, logic [1:0] sl);
    cfgScale = sc; lowSel = sel; lowSup = sup; cfgSlope = sl;
    cfgWrite = 1;
    cyc(1);
    cfgWrite = 0;
    cyc(1);
  endtask
  // bounded wait for the serial unit to leave reset
  task automatic waitSerial;
    for (int i = 0; i < 10 && srn !== 1'b1; i++) cyc(1);
    if (srn !== 1'b1) begin
      n_errors++;
      stop_test;
    end
  endtask
  // one polarity change on a coil, with or without a chopper event before it
  task automatic pol(int c, bit chop, int cur);
    if (c == 0) begin
      cA.actualCurrent = 5'(cur); cA.chopEvent = chop;
    end else begin
      cB.actualCurrent = 5'(cur); cB.chopEvent = chop;
    end
    cyc(1);
    cA.chopEvent = 0; cB.chopEvent = 0;
    if (c == 0) cA.polarity = ~cA.polarity;
    else cB.polarity = ~cB.polarity;
    // low current leaves the flag as it was
    if (olPrev[c] != 0 && cur >= int'(CUR_MAX >> CUR_SIXTEENTH_SHIFT)) olExp[c] = !chop;
    olPrev[c] = 1;
    cyc(3);
    chk("openLoad", 32'(status.openLoad), {olExp[1][0], olExp[0][0]});
  endtask
  task automatic stop_test;
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ************************************************************
  // watchdog and main sequence
  // ************************************************************
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    stop_test;
  end
  initial begin
    cA.actualCurrent = 5'(($random(seed) & 15) + 1);
    repeat (20) @(posedge sys_clk);
    #1;
    chk("powerStageOff", pso, 1);
    nrst = 1;
    chk("serialResetN", srn, 0);
    // a write during start-up must be ignored
    cfgScale = CUR_MAX; cfgWrite = 1;
    cyc(1);
    cfgWrite = 0;
    waitSerial;
    driverRequest = 1;
    cyc(2);
    chk("actualCurrentValue", acv, 0);
    cfg(CUR_MAX, 0, 1, SLOPE_MIN);
    chk("actualCurrentValue", acv, 32'(cA.actualCurrent));
    chk("dampingEnable", dmp, 1);
    chk("driverEnable", drvEn, 1);
    // gate step only in the two compensated modes
    for (s = 0; s < 4; s++) begin
      cfg(CUR_MAX, 0, 1, 2'(s));
      chk("gate", gate, s);
      ain.tempPrewarn = 1;
      cyc(4);
      chk("gate", gate, (s == 1 || s == 2) ? s + 1 : s);
      chk("prewarn", status.tempPrewarningFlag, 1);
      ain.tempPrewarn = 0;
      cyc(4);
      chk("prewarn", status.tempPrewarningFlag, 0);
    end
    ain.tempRelease = 1; ain.tempShutLow = 1;
    cyc(4);
    chk("shutdown", status.tempShutdownFlag, 0);
    ain.tempShutHigh = 1;
    cyc(4);
    chk("shutdown", status.tempShutdownFlag, 1);
    chk("driverEnable", drvEn, 0);
    chk("powerStageOff", pso, 1);
    ain.tempShutHigh = 0; ain.tempShutLow = 0;
    cyc(4);
    chk("driverEnable", drvEn, 0);
    ain.tempRelease = 0;
    cyc(4);
    chk("driverEnable", drvEn, 1);
    cfg(CUR_MAX, 1, 1, SLOPE_MIN);
    ain.tempShutLow = 1; ain.tempRelease = 1;
    cyc(4);
    chk("shutdown", status.tempShutdownFlag, 1);
    ain.tempShutLow = 0; ain.tempRelease = 0;
    cyc(4);
    // open-load, the host reads it as during microstepping
    rc = ($random(seed) & 15) + 1;
    pol(0, 0, rc);
    pol(0, 0, rc);
    pol(0, 1, rc);
    pol(0, 0, 31);
    pol(0, 1, 0);
    chk("driverEnable", drvEn, 1);
    pol(1, 0, rc);
    pol(1, 0, rc);
    // one link frame of eight clocks
    rc = rises;
    frameGo = 1;
    cyc(1);
    frameGo = 0;
    cyc(80);
    chk("linkRises", rises - rc, 8);
    // lower threshold selected: the higher comparator alone is harmless
    ain.coreUnderHigh = 1;
    cyc(4);
    chk("logicResetN", lrn, 1);
    ain.coreUnderLow = 1;
    cyc(4);
    chk("logicResetN", lrn, 0);
    chk("powerStageOff", pso, 1);
    chk("status", 32'(status), 0);
    chk("dampingEnable", dmp, 0);
    chk("serialResetN", srn, 0);
    ain.coreUnderLow = 0; ain.coreUnderHigh = 0;
    olPrev = '{0, 0}; olExp = '{0, 0};
    cyc(3);
    waitSerial;
    cyc(1);
    chk("actualCurrentValue", acv, 0);
    cfg(CUR_MAX, 0, 0, SLOPE_MIN);
    chk("driverEnable", drvEn, 1);
    ain.ioUnder = 1;
    cyc(4);
    chk("logicResetN", lrn, 0);
    ain.ioUnder = 0;
    cyc(3);
    waitSerial;
    // low-supply bit cleared again: the higher threshold alone resets
    ain.coreUnderHigh = 1;
    cyc(4);
    chk("logicResetN", lrn, 0);
    ain.coreUnderHigh = 0;
    cyc(3);
    waitSerial;
    driverRequest = 0;
    cyc(3);
    chk("driverEnable", drvEn, 0);
    stop_test;
  end
endmodule
